// File: can_ctl_pkg.sv
// Package: register map, field positions and reset values of the CAN control block
package can_ctl_pkg;
    // Register byte offsets
    localparam logic [7:0] INT_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] MASK_BASE = 8'h10;
    localparam logic [7:0] FLTCON_OFS = 8'h20;
    localparam logic [7:0] FID_BASE = 8'h30;
    localparam logic [7:0] FIFOCON_BASE = 8'h40;
    localparam logic [7:0] FIFOSTAT_BASE = 8'h80;
    localparam int REG_STRIDE = 4;

    // Interrupt enable/flag register
    localparam logic [31:0] INT_WMASK = 32'hf80f_f80f;
    localparam logic [31:0] INT_RESET = 32'h0000_0000;
    localparam int NUM_IRQ_SRC = 9;
    localparam int IRQ_EN_LSB = 16;
    localparam int HIGH_SRC_LSB = 4;
    localparam int HIGH_SRC_SHIFT = 7;
    localparam int SERR_FLAG_POS = 12;

    // Module control register
    localparam int ON_POS = 15;
    localparam int OPMODE_LSB = 21;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam logic [2:0] OPMODE_RESET = 3'h4;

    // Acceptance mask and filter identifier layout
    localparam int SID_LSB = 21;
    localparam int ID_TYPE_POS = 19;
    localparam logic [31:0] MASK_WMASK = 32'hffeb_ffff;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // Filter control byte layout
    localparam int FLT_BYTE = 8;
    localparam int FLT_EN_POS = 7;
    localparam int FLT_MSEL_LSB = 5;
    localparam logic [7:0] FLT_RESET = 8'h00;
    localparam logic [4:0] FIFO_SEL_RESERVED = 5'h10;

    // FIFO control layout
    localparam int FSIZE_LSB = 16;
    localparam int FIFO_RESET_REQ_POS = 14;
    localparam int STEP_POS = 13;
    localparam int PAYLOAD_ONLY_STORE_POS = 12;
    localparam int FIFO_IS_TRANSMIT_POS = 7;
    localparam int ABAT_POS = 6;
    localparam int ARB_POS = 5;
    localparam int TX_ERROR_SEEN_POS = 4;
    localparam int TX_REQUEST_POS = 3;
    localparam int REMOTE_REQUEST_ENABLE_POS = 2;
    localparam logic [4:0] FSIZE_RESERVED = 5'h10;
    localparam logic [4:0] FSIZE_RESET = 5'h00;

    // FIFO pointer status layout
    localparam int HEAD_LSB = 0;
    localparam int TAIL_LSB = 8;
endpackage

// File: can_filter_fifo_irq_control.sv
// CAN control block: interrupts, acceptance masks, filter steering and FIFO control
//
// Operation
// - Nine interrupt sources, enable in upper half, flag in lower half, reset zero.
// - Invalid-message flag set whenever an invalid message is received.
// - System-error flag cleared only by turning the module off then on.
// - Masks hold 11 standard and 18 extended bits; one compares, zero ignores.
// - Type bit set demands message type equal filter extended flag.
// - Mask registers writable only in configuration mode.
// - Each filter owns one control byte: enable, mask select, FIFO select.
// - Mask select codes 0 to 3 apply acceptance masks 0 to 3.
// - Matching message goes to FIFO named by select; codes 16 up reserved.
// - Filter control bits other than enable change only while that filter is disabled.
// - FIFO size field holds depth minus one; 16 and up reserved.
// - FIFO size and data-only fields writable only in configuration mode.
// - FIFO reset bit resets the FIFO, then hardware clears the bit.
// - Step bit advances transmit head or receive tail by one message.
// - Data-only bit stores payload alone for receive FIFOs only.
// - Direction bit one makes a transmit FIFO, zero a receive FIFO.
// - Transmit-aborted status updates on completion, abort or FIFO reset.
// - Arbitration-lost and error status clear on control read or reset.
//
// Implementation choices: the register offsets and the strobed register port.
module can_filter_fifo_irq_control #(
    parameter int NUM_FILTERS = 3,
    parameter int NUM_FIFOS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic [8:0] irq_event,
    input wire logic msg_valid,
    input wire logic [10:0] msg_sid,
    input wire logic [17:0] msg_eid,
    input wire logic msg_is_ext,
    input wire logic tx_done,
    input wire logic tx_abort,
    input wire logic [3:0] tx_fifo,
    input wire logic tx_arb_lost,
    input wire logic tx_error,
    output logic store_valid,
    output logic [3:0] store_fifo,
    output logic store_payload_only
);
    // Elaboration check of the sizing parameters
    generate
        if (NUM_FILTERS < 1 || NUM_FILTERS > 4) begin : g_bad_filters
            $error("NUM_FILTERS must lie between 1 and 4");
        end
        if (NUM_FIFOS < 1 || NUM_FIFOS > 16) begin : g_bad_fifos
            $error("NUM_FIFOS must lie between 1 and 16");
        end
    endgenerate

    typedef struct packed {
        // Registered outputs
        logic [31:0] rdata;
        logic irq;
        logic store_valid;
        logic [3:0] store_fifo;
        logic store_payload_only;

        // Register contents
        logic [31:0] intr;
        logic on;
        logic [2:0] opmode;
        logic [3:0][31:0] mask;
        logic [NUM_FILTERS-1:0][7:0] fltcon;
        logic [NUM_FILTERS-1:0][31:0] fid;

        // Per-FIFO fields
        logic [NUM_FIFOS-1:0][4:0] fsize;
        logic [NUM_FIFOS-1:0] fifo_reset_req;
        logic [NUM_FIFOS-1:0] payload_only_store;
        logic [NUM_FIFOS-1:0] fifo_is_transmit;
        logic [NUM_FIFOS-1:0] abat;
        logic [NUM_FIFOS-1:0] larb;
        logic [NUM_FIFOS-1:0] tx_error_seen;
        logic [NUM_FIFOS-1:0] tx_request;
        logic [NUM_FIFOS-1:0] remote_request_enable;
        logic [NUM_FIFOS-1:0][1:0] prio;
        logic [NUM_FIFOS-1:0][3:0] head;
        logic [NUM_FIFOS-1:0][3:0] tail;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Reset and mode decode
    logic [1:0] rst_sync_reg;
    logic rst_sync_n;
    logic config_mode;
    logic on_rise;

    // Filter results
    logic [NUM_FILTERS-1:0] filter_hit;
    logic [NUM_FILTERS-1:0][4:0] filter_target;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_reg[1];

    // Pointer step with wrap at the programmed depth
    function automatic logic [3:0] ptr_step(input logic [3:0] ptr, input logic [4:0] size);
        ptr_step = (ptr == size[3:0]) ? 4'h0 : ptr + 4'h1;
    endfunction

    // Bit position of interrupt flag for source index
    function automatic int flag_pos(input int src);
        flag_pos = (src >= can_ctl_pkg::HIGH_SRC_LSB) ? src + can_ctl_pkg::HIGH_SRC_SHIFT : src;
    endfunction

    assign config_mode = (state_reg.opmode == can_ctl_pkg::MODE_CONFIG);
    assign on_rise = wr && (addr == can_ctl_pkg::CTRL_OFS) && wdata[can_ctl_pkg::ON_POS]
        && !state_reg.on;

    // Per-filter comparison against its selected mask
    generate
        for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filter
            logic [31:0] sel_mask;
            logic [31:0] ident;
            logic sid_ok;
            logic eid_ok;
            logic type_ok;
            logic sel_ok;

            assign ident = state_reg.fid[f];
            assign sel_mask =
                state_reg.mask[state_reg.fltcon[f][can_ctl_pkg::FLT_MSEL_LSB +: 2]];
            assign filter_target[f] = state_reg.fltcon[f][4:0];

            assign sid_ok = ((ident[31:21] ^ msg_sid) & sel_mask[31:21]) == 11'h000;
            assign eid_ok = !msg_is_ext
                || (((ident[17:0] ^ msg_eid) & sel_mask[17:0]) == 18'h00000);

            assign type_ok = !sel_mask[can_ctl_pkg::ID_TYPE_POS]
                || (msg_is_ext == ident[can_ctl_pkg::ID_TYPE_POS]);

            assign sel_ok = (filter_target[f] < can_ctl_pkg::FIFO_SEL_RESERVED)
                && (filter_target[f] < 5'(NUM_FIFOS));

            assign filter_hit[f] = state_reg.fltcon[f][can_ctl_pkg::FLT_EN_POS] && sid_ok
                && eid_ok && type_ok && sel_ok;
        end
    endgenerate

    // Next-state logic for the whole block
    always_comb begin
        state_next = state_reg;
        state_next.store_valid = 1'b0;
        state_next.rdata = 32'h0000_0000;

        // Module control: switch and operating mode
        if (wr && addr == can_ctl_pkg::CTRL_OFS) begin
            state_next.on = wdata[can_ctl_pkg::ON_POS];
            state_next.opmode = wdata[can_ctl_pkg::OPMODE_LSB +: 3];
        end

        // Interrupt register, system-error flag held against writes
        if (wr && addr == can_ctl_pkg::INT_OFS) begin
            state_next.intr = (wdata & can_ctl_pkg::INT_WMASK);
            state_next.intr[can_ctl_pkg::SERR_FLAG_POS] =
                state_reg.intr[can_ctl_pkg::SERR_FLAG_POS];
        end

        // Off-to-on switch clears it
        if (on_rise) begin
            state_next.intr[can_ctl_pkg::SERR_FLAG_POS] = 1'b0;
        end

        // Hardware events win over a clear in the same cycle
        for (int i = 0; i < can_ctl_pkg::NUM_IRQ_SRC; i++) begin
            if (irq_event[i]) begin
                state_next.intr[flag_pos(i)] = 1'b1;
            end
        end

        // Acceptance masks, only in configuration mode
        for (int m = 0; m < 4; m++) begin
            if (wr && config_mode
                && addr == 8'(can_ctl_pkg::MASK_BASE + can_ctl_pkg::REG_STRIDE * m)) begin
                state_next.mask[m] = wdata & can_ctl_pkg::MASK_WMASK;
            end
        end

        // Filter control bytes and identifiers
        for (int f = 0; f < NUM_FILTERS; f++) begin
            // Control byte
            if (wr && addr == can_ctl_pkg::FLTCON_OFS) begin
                if (!state_reg.fltcon[f][can_ctl_pkg::FLT_EN_POS]) begin
                    state_next.fltcon[f] = wdata[f*can_ctl_pkg::FLT_BYTE +: 8];
                end else begin
                    // Enabled filter: only turning it off is taken
                    state_next.fltcon[f][can_ctl_pkg::FLT_EN_POS] =
                        wdata[f*can_ctl_pkg::FLT_BYTE + can_ctl_pkg::FLT_EN_POS];
                end
            end

            // Identifier word
            if (wr && !state_reg.fltcon[f][can_ctl_pkg::FLT_EN_POS]
                && addr == 8'(can_ctl_pkg::FID_BASE + can_ctl_pkg::REG_STRIDE * f)) begin
                state_next.fid[f] = wdata & can_ctl_pkg::MASK_WMASK;
            end
        end

        // Per-FIFO control, status and pointers
        for (int q = 0; q < NUM_FIFOS; q++) begin
            if (wr && addr == 8'(can_ctl_pkg::FIFOCON_BASE + can_ctl_pkg::REG_STRIDE * q)) begin
                state_next.fifo_is_transmit[q] = wdata[can_ctl_pkg::FIFO_IS_TRANSMIT_POS];
                state_next.tx_request[q] = wdata[can_ctl_pkg::TX_REQUEST_POS];
                state_next.remote_request_enable[q] = wdata[can_ctl_pkg::REMOTE_REQUEST_ENABLE_POS];
                state_next.prio[q] = wdata[1:0];

                // Configuration-mode fields
                if (config_mode) begin
                    state_next.payload_only_store[q] = wdata[can_ctl_pkg::PAYLOAD_ONLY_STORE_POS];
                    if (wdata[can_ctl_pkg::FSIZE_LSB +: 5] < can_ctl_pkg::FSIZE_RESERVED) begin
                        state_next.fsize[q] = wdata[can_ctl_pkg::FSIZE_LSB +: 5];
                    end
                end
                // Reset request
                if (wdata[can_ctl_pkg::FIFO_RESET_REQ_POS]) begin
                    state_next.fifo_reset_req[q] = 1'b1;
                end
                // Pointer step
                if (wdata[can_ctl_pkg::STEP_POS]) begin
                    if (state_reg.fifo_is_transmit[q]) begin
                        state_next.head[q] = ptr_step(state_reg.head[q], state_reg.fsize[q]);
                    end else begin
                        state_next.tail[q] = ptr_step(state_reg.tail[q], state_reg.fsize[q]);
                    end
                end
            end

            // Read clears the one-shot transmit status
            if (rd && addr == 8'(can_ctl_pkg::FIFOCON_BASE + can_ctl_pkg::REG_STRIDE * q)) begin
                state_next.larb[q] = 1'b0;
                state_next.tx_error_seen[q] = 1'b0;
            end

            // Transmit outcome from the frame engine
            if (tx_fifo == 4'(q)) begin
                if (tx_done) begin
                    state_next.abat[q] = tx_abort;
                    state_next.tx_request[q] = 1'b0;
                    state_next.tail[q] = ptr_step(state_reg.tail[q], state_reg.fsize[q]);
                end
                if (tx_arb_lost) begin
                    state_next.larb[q] = 1'b1;
                end
                if (tx_error) begin
                    state_next.tx_error_seen[q] = 1'b1;
                end
            end

            // Pending reset clears pointers and status, then drops itself
            if (state_reg.fifo_reset_req[q]) begin
                state_next.fifo_reset_req[q] = 1'b0;
                state_next.head[q] = 4'h0;
                state_next.tail[q] = 4'h0;
                state_next.abat[q] = 1'b0;
                state_next.larb[q] = 1'b0;
                state_next.tx_error_seen[q] = 1'b0;
                state_next.tx_request[q] = 1'b0;
            end
        end

        // Steering of an accepted message, lowest filter first
        if (msg_valid) begin
            for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
                if (filter_hit[f] && !state_reg.fifo_is_transmit[filter_target[f][3:0]]) begin
                    state_next.store_valid = 1'b1;
                    state_next.store_fifo = filter_target[f][3:0];
                end
            end

            // Data-only bit and head advance
            if (state_next.store_valid) begin
                state_next.store_payload_only = state_reg.payload_only_store[state_next.store_fifo];
                state_next.head[state_next.store_fifo] = ptr_step(
                    state_reg.head[state_next.store_fifo],
                    state_reg.fsize[state_next.store_fifo]);
            end
        end

        // Read data mux, unmapped addresses read zero
        if (rd) begin
            // Interrupt word
            if (addr == can_ctl_pkg::INT_OFS) begin
                state_next.rdata = state_reg.intr;
            end

            // Control word
            if (addr == can_ctl_pkg::CTRL_OFS) begin
                state_next.rdata[can_ctl_pkg::ON_POS] = state_reg.on;
                state_next.rdata[can_ctl_pkg::OPMODE_LSB +: 3] = state_reg.opmode;
            end

            // Mask words
            for (int m = 0; m < 4; m++) begin
                if (addr == 8'(can_ctl_pkg::MASK_BASE + can_ctl_pkg::REG_STRIDE * m)) begin
                    state_next.rdata = state_reg.mask[m];
                end
            end

            // Filter words
            for (int f = 0; f < NUM_FILTERS; f++) begin
                if (addr == can_ctl_pkg::FLTCON_OFS) begin
                    state_next.rdata[f*can_ctl_pkg::FLT_BYTE +: 8] = state_reg.fltcon[f];
                end
                if (addr == 8'(can_ctl_pkg::FID_BASE + can_ctl_pkg::REG_STRIDE * f)) begin
                    state_next.rdata = state_reg.fid[f];
                end
            end

            // FIFO words
            for (int q = 0; q < NUM_FIFOS; q++) begin
                if (addr == 8'(can_ctl_pkg::FIFOCON_BASE + can_ctl_pkg::REG_STRIDE * q)) begin
                    state_next.rdata[can_ctl_pkg::FSIZE_LSB +: 5] = state_reg.fsize[q];
                    state_next.rdata[can_ctl_pkg::FIFO_RESET_REQ_POS] = state_reg.fifo_reset_req[q];
                    state_next.rdata[can_ctl_pkg::PAYLOAD_ONLY_STORE_POS] = state_reg.payload_only_store[q];
                    state_next.rdata[can_ctl_pkg::FIFO_IS_TRANSMIT_POS] = state_reg.fifo_is_transmit[q];
                    state_next.rdata[can_ctl_pkg::ABAT_POS] = state_reg.abat[q];
                    state_next.rdata[can_ctl_pkg::ARB_POS] = state_reg.larb[q];
                    state_next.rdata[can_ctl_pkg::TX_ERROR_SEEN_POS] = state_reg.tx_error_seen[q];
                    state_next.rdata[can_ctl_pkg::TX_REQUEST_POS] = state_reg.tx_request[q];
                    state_next.rdata[can_ctl_pkg::REMOTE_REQUEST_ENABLE_POS] = state_reg.remote_request_enable[q];
                    state_next.rdata[1:0] = state_reg.prio[q];
                end
                if (addr == 8'(can_ctl_pkg::FIFOSTAT_BASE + can_ctl_pkg::REG_STRIDE * q)) begin
                    state_next.rdata[can_ctl_pkg::HEAD_LSB +: 4] = state_reg.head[q];
                    state_next.rdata[can_ctl_pkg::TAIL_LSB +: 4] = state_reg.tail[q];
                end
            end
        end

        // Interrupt request from the updated flags and enables
        state_next.irq = |(state_next.intr[31:can_ctl_pkg::IRQ_EN_LSB]
            & state_next.intr[can_ctl_pkg::IRQ_EN_LSB-1:0]);
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= '0;
            state_reg.intr <= can_ctl_pkg::INT_RESET;
            state_reg.opmode <= can_ctl_pkg::OPMODE_RESET;
            state_reg.mask <= {4{can_ctl_pkg::MASK_RESET}};
            state_reg.fltcon <= {NUM_FILTERS{can_ctl_pkg::FLT_RESET}};
            state_reg.fsize <= {NUM_FIFOS{can_ctl_pkg::FSIZE_RESET}};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state flops
    assign rdata = state_reg.rdata;
    assign irq = state_reg.irq;
    assign store_valid = state_reg.store_valid;
    assign store_fifo = state_reg.store_fifo;
    assign store_payload_only = state_reg.store_payload_only;
endmodule

// File: can_ctl_checker.sv
// Checker on the register port, interrupt line and message store outputs
module can_ctl_checker #(
    parameter int NUM_FIFOS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd,
    input wire logic [7:0] addr,
    input wire logic [31:0] rdata,
    input wire logic irq,
    input wire logic msg_valid,
    input wire logic store_valid,
    input wire logic [3:0] store_fifo,
    input wire logic store_payload_only
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Read data only in the slot after a read
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read slot");
    chk_int_reserved: assert property ($past(rd) && $past(addr) == can_ctl_pkg::INT_OFS
        |-> (rdata & ~can_ctl_pkg::INT_WMASK) == 32'h0) else $error("unused int bit set");
    // Request equals enabled flags seen by the read
    chk_irq_matches: assert property ($past(rd) && $past(addr) == can_ctl_pkg::INT_OFS
        |-> $past(irq) == |(rdata[31:16] & rdata[15:0])) else $error("irq disagrees");
    chk_mask_reserved: assert property ($past(rd) && $past(addr[7:4]) == 4'h1
        |-> rdata[20] == 1'b0 && rdata[18] == 1'b0) else $error("unused mask bit set");
    // Size below 16, step bit and unused bits read zero
    chk_fifo_reserved: assert property ($past(rd) && $past(addr[7:6]) == 2'b01
        |-> (rdata & 32'hfff0_af00) == 32'h0) else $error("fifo control bad bits");
    chk_store_cause: assert property (store_valid |-> $past(msg_valid))
        else $error("store without message");
    chk_store_hold: assert property (!store_valid
        |-> $stable(store_fifo) && $stable(store_payload_only)) else $error("store target moved");
    chk_store_range: assert property (store_valid |-> int'(store_fifo) < NUM_FIFOS)
        else $error("store to missing fifo");
endmodule

bind can_filter_fifo_irq_control can_ctl_checker #(.NUM_FIFOS(NUM_FIFOS)) chk_u (
    .clk(clk), .rst_n(rst_n), .rd(rd), .addr(addr), .rdata(rdata), .irq(irq),
    .msg_valid(msg_valid), .store_valid(store_valid), .store_fifo(store_fifo),
    .store_payload_only(store_payload_only));

// File: can_node_model.sv
// Far-side node: presents received message ids and transmit outcomes
module can_node_model (
    input wire logic clk,
    output logic msg_valid,
    output logic [10:0] msg_sid,
    output logic [17:0] msg_eid,
    output logic msg_is_ext,
    output logic tx_done,
    output logic tx_abort,
    output logic [3:0] tx_fifo,
    output logic tx_arb_lost,
    output logic tx_error
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {msg_valid, msg_sid, msg_eid, msg_is_ext} = '0;
        {tx_done, tx_abort, tx_fifo, tx_arb_lost, tx_error} = '0;
    end
    // One received frame id for a single cycle
    task automatic send(input logic [10:0] sid, input logic ext);
        @(posedge clk);
        msg_valid <= 1'b1;
        msg_sid <= sid;
        msg_eid <= {sid, 7'h5a};
        msg_is_ext <= ext;
        @(posedge clk);
        msg_valid <= 1'b0;
        msg_sid <= ~sid; // No stale id once the frame is gone
    endtask
    // Outcome pulse: done, aborted, arbitration lost, error
    task automatic tx_event(input logic [3:0] f, input logic [3:0] kind);
        @(posedge clk);
        tx_fifo <= f;
        {tx_done, tx_abort, tx_arb_lost, tx_error} <= kind;
        @(posedge clk);
        {tx_done, tx_abort, tx_arb_lost, tx_error} <= 4'h0;
        tx_fifo <= ~f;
    endtask
endmodule

// File: can_filter_fifo_irq_control_bench.sv
// Bench: register sequences with expected values for the CAN control block
module can_filter_fifo_irq_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ce, wr, rd, irq, store_valid, store_payload_only;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got, exp;
    logic [8:0] irq_event;
    logic msg_valid, msg_is_ext, tx_done, tx_abort, tx_arb_lost, tx_error;
    logic [10:0] msg_sid;
    logic [17:0] msg_eid;
    logic [3:0] tx_fifo, store_fifo;
    int err_count;
    int check_count;

    can_filter_fifo_irq_control #(.NUM_FILTERS(3), .NUM_FIFOS(16)) dut_u (
        .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .irq_event(irq_event), .msg_valid(msg_valid),
        .msg_sid(msg_sid), .msg_eid(msg_eid), .msg_is_ext(msg_is_ext), .tx_done(tx_done),
        .tx_abort(tx_abort), .tx_fifo(tx_fifo), .tx_arb_lost(tx_arb_lost),
        .tx_error(tx_error), .store_valid(store_valid), .store_fifo(store_fifo),
        .store_payload_only(store_payload_only));
    can_node_model node_u (
        .clk(clk), .msg_valid(msg_valid), .msg_sid(msg_sid), .msg_eid(msg_eid),
        .msg_is_ext(msg_is_ext), .tx_done(tx_done), .tx_abort(tx_abort), .tx_fifo(tx_fifo),
        .tx_arb_lost(tx_arb_lost), .tx_error(tx_error));

    // Verdict and end of run
    task automatic conclude;
        $display("Counts: %0d mismatches in %0d checks", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp1(input string what, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", what, e, s);
        end
    endtask
    // One-cycle write and read strobes
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        rd_reg(a);
        cmp32(what, e, got);
    endtask
    task automatic ev(input int i);
        @(posedge clk);
        irq_event <= 9'h1 << i;
        @(posedge clk);
        irq_event <= 9'h0;
    endtask
    // Frame in, then the accept pulse one cycle later
    task automatic msg_chk(input logic [10:0] sid, input logic x, input logic v,
        input logic [3:0] f);
        node_u.send(sid, x);
        #1;
        cmp1("store_valid", v, store_valid);
        if (v) cmp32("store_fifo", {28'h0, f}, {28'h0, store_fifo});
    endtask
    // Request a fifo reset and poll until hardware clears it
    task automatic fifo_reset(input logic [7:0] a, input logic [31:0] d);
        wr_reg(a, d | 32'h0000_4000);
        for (int n = 0; n < 8; n++) begin
            rd_reg(a);
            if (got[14] == 1'b0) break;
        end
        cmp32("fifo after reset", d, got);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        conclude();
    end
    initial begin
        {rst_n, wr, rd, addr, wdata, irq_event} = '0;
        ce = 1'b1;
        err_count = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values and an unmapped place
        rd_chk(8'h00, 32'h0, "int");
        rd_chk(8'h08, 32'h0080_0000, "ctrl");
        rd_chk(8'h20, 32'h0, "filter ctrl");
        rd_chk(8'h44, 32'h0, "fifo1 ctrl");
        wr_reg(8'hfc, 32'hffff_ffff);
        rd_chk(8'hfc, 32'h0, "unmapped");
        // Each source except 5 sets its own flag and raises the request
        for (int i = 0; i < 9; i++) begin
            if (i == 5) continue;
            wr_reg(8'h00, 32'hf80f_0000);
            ev(i);
            exp = 32'hf80f_0000 | (i < 4 ? 32'h1 << i : 32'h1 << (i + 7));
            rd_chk(8'h00, exp, "int flag");
            cmp1("irq", 1'b1, irq);
        end
        wr_reg(8'h00, 32'hffff_ffff);
        rd_chk(8'h00, 32'hf80f_e80f, "int all");
        wr_reg(8'h00, 32'h0);
        ev(5);
        wr_reg(8'h00, 32'h0);
        rd_chk(8'h00, 32'h0000_1000, "sys err kept");
        cmp1("irq masked", 1'b0, irq);
        wr_reg(8'h08, 32'h0080_0000);
        wr_reg(8'h08, 32'h0080_8000);
        rd_chk(8'h00, 32'h0, "sys err off-on");
        // Masks: 0 and 2 compare the standard id, 1 nothing, 3 the type
        wr_reg(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, 32'hffeb_ffff, "mask0");
        wr_reg(8'h10, 32'hffe0_0000);
        wr_reg(8'h14, 32'h0);
        wr_reg(8'h18, 32'hffe0_0000);
        wr_reg(8'h1c, 32'h0008_0000);
        wr_reg(8'h34, 32'h2460_0000);
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h20, 32'h0);
            wr_reg(8'h20, {16'h0, 1'b1, 2'(m), 5'(m + 1), 8'h00});
            msg_chk(11'h124, 1'b0, m[0], 4'(m + 1));
            msg_chk(11'h123, 1'b0, 1'b1, 4'(m + 1));
            cmp1("full message", 1'b0, store_payload_only);
            msg_chk(11'h123, 1'b1, m != 3, 4'(m + 1));
        end
        wr_reg(8'h20, 32'h0000_8f00);
        rd_chk(8'h20, 32'h0000_e400, "locked filter");
        wr_reg(8'h20, 32'h0);
        wr_reg(8'h20, 32'h0000_b000);
        msg_chk(11'h124, 1'b0, 1'b0, 4'h0);
        // Receive fifo 2: size, data-only, pointers, reset
        wr_reg(8'h30, 32'h2460_0000);
        wr_reg(8'h48, 32'h0003_1000);
        wr_reg(8'h48, 32'h0010_1000);
        rd_chk(8'h48, 32'h0003_1000, "fifo2 ctrl");
        wr_reg(8'h20, 32'h0000_b082);
        msg_chk(11'h123, 1'b0, 1'b1, 4'h2);
        cmp1("payload only", 1'b1, store_payload_only);
        msg_chk(11'h123, 1'b0, 1'b1, 4'h2);
        rd_chk(8'h88, 32'h0000_0002, "fifo2 head");
        wr_reg(8'h48, 32'h0003_3000);
        rd_chk(8'h88, 32'h0000_0102, "fifo2 tail");
        fifo_reset(8'h48, 32'h0003_1000);
        rd_chk(8'h88, 32'h0, "fifo2 cleared");
        wr_reg(8'h48, 32'h0003_1080);
        msg_chk(11'h123, 1'b0, 1'b0, 4'h2);
        // Transmit fifo 4 status bits and head step
        wr_reg(8'h50, 32'h0003_0080);
        node_u.tx_event(4'h4, 4'b0011);
        rd_chk(8'h50, 32'h0003_00b0, "tx status");
        rd_chk(8'h50, 32'h0003_0080, "read clears");
        node_u.tx_event(4'h4, 4'b1100);
        rd_chk(8'h50, 32'h0003_00c0, "aborted");
        wr_reg(8'h50, 32'h0003_2080);
        rd_chk(8'h90, 32'h0000_0101, "fifo4 ptrs");
        fifo_reset(8'h50, 32'h0003_0080);
        // Out of configuration mode masks and sizes hold
        wr_reg(8'h08, 32'h0000_8000);
        wr_reg(8'h10, 32'h0);
        rd_chk(8'h10, 32'hffe0_0000, "mask locked");
        wr_reg(8'h48, 32'h0);
        rd_chk(8'h48, 32'h0003_1000, "size locked");
        conclude();
    end
endmodule
